// >>> core/contact_pkg.sv
// Purpose: shared constants and types for the output contact driver
// Assumes: 40 MHz processing clock on mclk
// Notes:   pulse targets 0..6 main, 7 fault alarm, 8 and up expansion
package contact_pkg;
   // output counts
   localparam int unsigned MAIN_N       = 7;
   localparam int unsigned EXP_MAX      = 12;
   localparam int unsigned EXP_SMALL    = 8;
   localparam int unsigned SEVENTH_IDX  = 6;
   // pulse command target encoding
   localparam int unsigned TGT_W        = 5;
   localparam logic [4:0]  TGT_ALARM    = 5'h07;
   localparam logic [4:0]  TGT_EXP_BASE = 5'h08;
   // timing: default test pulse is one second
   localparam int unsigned CLK_KHZ       = 40000;
   localparam int unsigned PULSE_TIME_MS = 1000;
   localparam int unsigned CNT_W         = 26;
   localparam logic [CNT_W-1:0] PULSE_CYCLES_DEF =
      CNT_W'(PULSE_TIME_MS * CLK_KHZ);
   // contact type reset values: 1 means normally closed (form b)
   localparam logic [MAIN_N-1:0] MAIN_NC_RST  = 7'h00;
   localparam logic              ALARM_NC_RST = 1'b1;
   localparam logic [EXP_MAX-1:0] EXP_NC_RST  = 12'h000;
   localparam logic              EXTRA_RST    = 1'b0;

   // one pulse command, valid for a single cycle
   typedef struct packed {
      logic             valid;
      logic [TGT_W-1:0] target;
   } pulse_cmd_type;
endpackage : contact_pkg

// >>> core/pulse_timer.sv
// Purpose: retriggerable pulse stretcher for one output
// Assumes: start is a one-cycle pulse, len is at least one
// Notes:   active stays high for exactly len cycles after start
`timescale 1ns/1ps
module pulse_timer #(
   parameter int unsigned CNT_W = contact_pkg::CNT_W
) (
   input  wire logic             mclk,   // processing clock
   input  wire logic             nrst,   // sync reset, active low
   input  wire logic             start,  // load the count
   input  wire logic [CNT_W-1:0] len,    // pulse length in cycles
   output logic                  active  // pulse in progress
);
   import contact_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   // a new command reloads even mid-pulse, so the pulse restarts
   assign cnt_d  = start ? len :
                   (cnt_q != '0) ? cnt_q - CNT_W'(1) : cnt_q; // RQ14
   assign active = (cnt_q != '0);                             // RQ6

   // down counter
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   default clocking dc @(posedge mclk); endclocking
   default disable iff (!nrst);

   pulse_load_a: assert property (start |=> cnt_q == $past(len)) // RQ14
      else $error("pulse timer did not reload on start");
   pulse_count_a: assert property (!start && cnt_q != '0 |=>
      cnt_q == $past(cnt_q) - CNT_W'(1)) // RQ6
      else $error("pulse timer did not count down by one");
endmodule : pulse_timer

// >>> core/output_contact_driver.sv
// Purpose: drives output contact coils from logic bits and test pulses
// Assumes: inputs synchronous to mclk; contact jumpers static straps
// Notes:   every output registered; pulses and equations OR together
//
// Function
// RQ1: a running test pulse forces its main output bit to one
// RQ2: the output equation also sets the bit; both sources are ORed
// RQ3: the coil is energized exactly while its output bit is one
// RQ4: normally-open type: contact closed only while coil energized
// RQ5: normally-closed type: contact closed only while coil de-energized
// RQ6: a test pulse feeds a one for a default of one second
// RQ7: while operational the fault-alarm coil stays energized
// RQ8: while operational the alarm bit is zero; coil is its inverse
// RQ9: an alarm test pulse briefly raises the bit and drops the coil
// RQ10: entering privilege level two briefly raises the alarm bit
// RQ11: a jumper makes the seventh main output an extra alarm output
// RQ12: main outputs default normally-open, alarm defaults normally-closed
// RQ13: expansion board gives eight or twelve outputs with the same logic
// RQ14: pulse length is a cycle count; a repeat command restarts it
`timescale 1ns/1ps
module output_contact_driver #(
   parameter int unsigned EXP_N = contact_pkg::EXP_MAX,
   parameter logic [contact_pkg::CNT_W-1:0] PULSE_CYCLES =
      contact_pkg::PULSE_CYCLES_DEF
) (
   input  wire logic                        mclk,      // 40 MHz clock
   input  wire logic                        nrst,      // sync reset, low
   input  wire logic [contact_pkg::MAIN_N-1:0] output_equation, // main eqs
   input  wire logic [EXP_N-1:0]            exp_equation, // expansion eqs
   input  wire contact_pkg::pulse_cmd_type  pulse_cmd, // test pulse cmd
   input  wire logic                        relay_operational, // healthy
   input  wire logic                        level2_entry, // level 2 entry
   input  wire logic                        extra_fault_select_jumper,
                                                       // 7th as alarm
   input  wire logic [contact_pkg::MAIN_N-1:0] main_type_jumper, // 1 = nc
   input  wire logic                        alarm_type_jumper, // 1 = nc
   input  wire logic [EXP_N-1:0]            exp_type_jumper, // 1 = nc
   input  wire logic                        expansion_fitted, // board in
   input  wire logic                        expansion_twelve, // 12 outs
   output logic [contact_pkg::MAIN_N-1:0]   main_output_bits, // logic bits
   output logic [contact_pkg::MAIN_N-1:0]   main_coil,  // coil drive
   output logic [contact_pkg::MAIN_N-1:0]   main_contact_closed, // contact
   output logic                             alarm_bit,  // alarm logic bit
   output logic                             alarm_coil, // alarm coil
   output logic                             alarm_contact_closed, // contact
   output logic [EXP_N-1:0]                 expansion_output_bits, // bits
   output logic [EXP_N-1:0]                 exp_coil,   // coil drive
   output logic [EXP_N-1:0]                 exp_contact_closed // contact
);
   import contact_pkg::*;

   localparam int unsigned N_TGT = 8 + EXP_N;

   // true when the command names target idx
   function automatic logic tgt_hit(pulse_cmd_type c, int unsigned idx);
      tgt_hit = c.valid && (c.target == TGT_W'(idx));
   endfunction : tgt_hit

   logic [N_TGT-1:0]  pulse_start;
   logic [N_TGT-1:0]  pulse_act;
   logic [EXP_N-1:0]  exp_en;
   logic              strap_q;
   logic              extra_q;
   logic [MAIN_N-1:0] main_nc_q;
   logic              alarm_nc_q;
   logic [EXP_N-1:0]  exp_nc_q;
   logic [MAIN_N-1:0] main_bit_d;
   logic [MAIN_N-1:0] main_coil_d;
   logic              alarm_bit_d;
   logic              alarm_coil_d;
   logic [EXP_N-1:0]  exp_bit_d;

   // one retriggerable timer per target; alarm also fires on level 2
   for (genvar i = 0; i < N_TGT; i++) begin : g_tmr
      if (i == 7) begin : g_alarm
         assign pulse_start[i] = tgt_hit(pulse_cmd, i) || level2_entry;
      end else begin : g_plain
         assign pulse_start[i] = tgt_hit(pulse_cmd, i);
      end
      pulse_timer #(.CNT_W(CNT_W)) u_tmr (
         .mclk   (mclk),
         .nrst   (nrst),
         .start  (pulse_start[i]),
         .len    (PULSE_CYCLES),
         .active (pulse_act[i])
      );
   end

   // expansion outputs above eight exist only on the twelve-output board
   for (genvar j = 0; j < EXP_N; j++) begin : g_en
      assign exp_en[j] = expansion_fitted &&
                         ((j < EXP_SMALL) || expansion_twelve); // RQ13
   end

   // alarm bit rests at zero while healthy, coil is its inverse
   assign alarm_bit_d  = !relay_operational || pulse_act[7]; // RQ8 RQ9 RQ10
   assign alarm_coil_d = !alarm_bit_d;                       // RQ7

   // main bits: equation ORed with pulse; seventh may follow the alarm
   assign main_bit_d = extra_q ?
      {alarm_bit_d, output_equation[5:0] | pulse_act[5:0]} :
      (output_equation | pulse_act[6:0]);                    // RQ1 RQ2 RQ11
   assign main_coil_d = extra_q ?
      {alarm_coil_d, main_bit_d[5:0]} : main_bit_d;          // RQ3 RQ11

   // expansion bits use the same equation-or-pulse logic
   assign exp_bit_d = (exp_equation | pulse_act[N_TGT-1:8]) & exp_en; // RQ13

   // jumpers are straps: caught once at the first edge after reset,
   // so a jumper that bounces later cannot flip a live contact
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         strap_q    <= 1'b0;
         extra_q    <= EXTRA_RST;
         main_nc_q  <= MAIN_NC_RST;            // RQ12
         alarm_nc_q <= ALARM_NC_RST;           // RQ12
         exp_nc_q   <= EXP_NC_RST[EXP_N-1:0];
      end else if (!strap_q) begin
         strap_q    <= 1'b1;
         extra_q    <= extra_fault_select_jumper;
         main_nc_q  <= main_type_jumper;
         alarm_nc_q <= alarm_type_jumper;
         exp_nc_q   <= exp_type_jumper;
      end
   end

   // output registers; reset leaves every coil dropped, alarm included;
   // reset forces the alarm coil low and the alarm bit high whatever relay_operational is
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         main_output_bits      <= '0;
         main_coil             <= '0;
         main_contact_closed   <= MAIN_NC_RST;
         alarm_bit             <= 1'b1;
         alarm_coil            <= 1'b0;
         alarm_contact_closed  <= ALARM_NC_RST;
         expansion_output_bits <= '0;
         exp_coil              <= '0;
         exp_contact_closed    <= EXP_NC_RST[EXP_N-1:0];
      end else begin
         main_output_bits      <= main_bit_d;
         main_coil             <= main_coil_d;                 // RQ3
         main_contact_closed   <= main_coil_d ^ main_nc_q;     // RQ4 RQ5
         alarm_bit             <= alarm_bit_d;
         alarm_coil            <= alarm_coil_d;
         alarm_contact_closed  <= alarm_coil_d ^ alarm_nc_q;   // RQ4 RQ5
         expansion_output_bits <= exp_bit_d;
         exp_coil              <= exp_bit_d;                   // RQ3
         exp_contact_closed    <= exp_bit_d ^ exp_nc_q;        // RQ4 RQ5
      end
   end

   default clocking dc @(posedge mclk); endclocking
   default disable iff (!nrst);

   // output checks; a contact lags its coil input by one edge, so the
   // form it is compared against is the strap value one cycle back
   pulse_main_a: assert property ( // RQ1
      tgt_hit(pulse_cmd, 0) |-> ##2 main_output_bits[0] [*3])
      else $error("pulse did not raise main output zero");
   equation_or_a: assert property ( // RQ2
      1 |=> ((main_output_bits[5:0] & $past(output_equation[5:0]))
             == $past(output_equation[5:0])))
      else $error("equation one did not reach main output");
   coil_follow_a: assert property ( // RQ3
      main_coil[5:0] == main_output_bits[5:0] &&
      exp_coil == expansion_output_bits)
      else $error("coil does not follow output bit");
   open_type_a: assert property ( // RQ4
      (main_contact_closed & ~$past(main_nc_q)) ==
      (main_coil & ~$past(main_nc_q)) &&
      ($past(alarm_nc_q) || alarm_contact_closed == alarm_coil))
      else $error("normally-open contact state wrong");
   closed_type_a: assert property ( // RQ5
      (main_contact_closed & $past(main_nc_q)) ==
      (~main_coil & $past(main_nc_q)) &&
      (!$past(alarm_nc_q) || alarm_contact_closed == !alarm_coil))
      else $error("normally-closed contact state wrong");
   alarm_healthy_a: assert property ( // RQ7
      relay_operational && !pulse_act[7] |=> alarm_coil && !alarm_bit)
      else $error("alarm coil not energized while healthy");
   alarm_inverse_a: assert property ( // RQ8
      alarm_coil == !alarm_bit)
      else $error("alarm coil not inverse of alarm bit");
   alarm_test_a: assert property ( // RQ9
      tgt_hit(pulse_cmd, 7) |-> ##2 (alarm_bit && !alarm_coil))
      else $error("alarm test pulse did not drop coil");
   level_two_a: assert property ( // RQ10
      level2_entry |-> ##2 (alarm_bit && !alarm_coil) [*2])
      else $error("level two entry did not pulse alarm");
   extra_alarm_a: assert property ( // RQ11
      extra_q && $past(extra_q) |->
      main_output_bits[6] == alarm_bit && main_coil[6] == alarm_coil)
      else $error("seventh output not following alarm");
   type_default_a: assert property ( // RQ12
      $rose(nrst) |-> main_nc_q == MAIN_NC_RST &&
      alarm_nc_q == ALARM_NC_RST && exp_nc_q == EXP_NC_RST[EXP_N-1:0])
      else $error("contact type defaults wrong after reset");
   exp_mask_a: assert property ( // RQ13
      1 |=> (expansion_output_bits & ~$past(exp_en)) == '0)
      else $error("absent expansion output driven");
   alarm_fault_a: assert property ( // RQ8
      !relay_operational |=> alarm_bit && !alarm_coil)
      else $error("alarm not raised while relay unhealthy");
   strap_hold_a: assert property ( // RQ11
      strap_q |=> $stable(extra_q) && $stable(main_nc_q) &&
      $stable(alarm_nc_q) && $stable(exp_nc_q))
      else $error("jumper straps changed after capture");
   exp_pulse_a: assert property ( // RQ13
      (tgt_hit(pulse_cmd, 11) && expansion_fitted) ##1 expansion_fitted
      |=> expansion_output_bits[3])
      else $error("expansion test pulse did not raise output");

   cover_main_pulse: cover property (tgt_hit(pulse_cmd, 3) ##2
      main_contact_closed[3]);
   cover_alarm_test: cover property (tgt_hit(pulse_cmd, 7) ##2
      alarm_contact_closed);
   cover_restart: cover property (tgt_hit(pulse_cmd, 3) ##[1:8]
      tgt_hit(pulse_cmd, 3));
   cover_extra: cover property (extra_q && main_coil[6]);
   cover_fault_drop: cover property (!relay_operational ##1 !alarm_coil);
endmodule : output_contact_driver

// >>> sim/contact_field_model.sv
// Purpose: field side of the output coils and their contacts
// Assumes: contact form straps stay static while observed
// Notes:   flags any contact that disagrees with its coil and form
`timescale 1ns/1ps
module contact_field_model #(
   parameter int unsigned N = 7
) (
   input  wire logic [N-1:0] coil,     // coil drive from the relay
   input  wire logic [N-1:0] type_nc,  // 1 = normally closed form
   input  wire logic [N-1:0] closed,   // contact state presented
   output logic      [N-1:0] field_on, // external circuit made
   output logic      [N-1:0] fault     // contact disagrees with coil
);
   // a closed contact makes the external field circuit
   assign field_on = closed;
   // form a follows its coil, form b is the inverse of it
   assign fault = closed ^ (coil ^ type_nc);
endmodule : contact_field_model

// >>> sim/tb_output_contact_driver.sv
// Purpose: self-checking bench for the output contact driver
// Assumes: short pulse length so the timed tests stay brief
// Notes:   straps are captured at the first edge after reset, so alarm mode needs a reset
`timescale 1ns/1ps
module tb_output_contact_driver;
   import contact_pkg::*;
   localparam int PN = 6;
   localparam logic [CNT_W-1:0] P = CNT_W'(PN);
   localparam logic [6:0] MT = 7'h55;
   logic          mclk, nrst, rop, l2, xj, fit, tw, ab, ac, ak, at;
   logic [6:0]    eq, mb, mc, mk, ff;
   logic [11:0]   xe, xb, xc, xk;
   pulse_cmd_type pc;
   int            bad_count, checks_done;

   output_contact_driver #(.EXP_N(12), .PULSE_CYCLES(P))
      u_output_contact_driver (.mclk(mclk), .nrst(nrst),
      .output_equation(eq), .exp_equation(xe), .pulse_cmd(pc),
      .relay_operational(rop), .level2_entry(l2),
      .extra_fault_select_jumper(xj), .main_type_jumper(MT),
      .alarm_type_jumper(at), .exp_type_jumper(12'hF0F),
      .expansion_fitted(fit), .expansion_twelve(tw),
      .main_output_bits(mb), .main_coil(mc), .main_contact_closed(mk),
      .alarm_bit(ab), .alarm_coil(ac), .alarm_contact_closed(ak),
      .expansion_output_bits(xb), .exp_coil(xc), .exp_contact_closed(xk));
   contact_field_model #(.N(7)) u_contact_field_model (.coil(mc),
      .type_nc(MT), .closed(mk), .field_on(), .fault(ff));

   // free-running processing clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step

   // one-cycle command; level two entry shares the alarm path
   task automatic pulse(input logic [4:0] t, input logic lv);
      @(posedge mclk);
      if (lv) begin
         l2 <= 1'b1;
      end else begin
         pc <= '{1'b1, t};
      end
      @(posedge mclk);
      l2 <= 1'b0;
      pc <= '{1'b0, t};
   endtask : pulse

   task automatic do_reset(input logic x);
      @(posedge mclk);
      nrst <= 1'b0;
      xj   <= x;
      at   <= !x;
      step(20);
      chk("reset_contacts", 7'h00, mk);
      chk("reset_alarm_contact", 1, ak);
      @(posedge mclk);
      nrst <= 1'b1;
      step(2);
   endtask : do_reset

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // the whole run needs well under two thousand cycles
   initial begin
      #(25ns * 4000);
      bad_count++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      give_verdict();
   end

   initial begin
      nrst = 1'b0; rop = 1'b1; l2 = 1'b0; xj = 1'b0; fit = 1'b1;
      tw = 1'b1; eq = '0; xe = '0; pc = '0; bad_count = 0; checks_done = 0;
      do_reset(1'b0);
      chk("alarm_bit", 0, ab);
      chk("alarm_coil", 1, ac);
      chk("alarm_contact", 0, ak);
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         @(posedge mclk);
         eq <= 7'(1 << i);
         step(1);
         chk("main_bits", 1 << i, mb);
         chk("main_coil", 1 << i, mc);
         chk("main_contact", 7'(1 << i) ^ MT, mk);
         chk("field_fault", 0, ff);
      end
      @(posedge mclk);
      eq <= 7'h00;
      $display("test equations done");
      pulse(5'h00, 1'b0);
      step(1);
      chk("pulse_start", 7'h01, mb);
      step(PN - 1);
      chk("pulse_last", 7'h01, mb);
      step(1);
      chk("pulse_end", 7'h00, mb);
      pulse(5'h03, 1'b0);
      pulse(5'h03, 1'b0);
      step(PN);
      chk("retrigger_last", 7'h08, mb);
      step(1);
      chk("retrigger_end", 7'h00, mb);
      pulse(5'h1F, 1'b0);
      step(2);
      chk("bad_target", 0, {mb, xb, ab});
      $display("test main pulses done");
      for (int k = 0; k < 2; k++) begin
         pulse(TGT_ALARM, k[0]);
         step(2);
         chk("alarm_pulse_bit", 1, ab);
         chk("alarm_pulse_coil", 0, ac);
         chk("alarm_pulse_contact", 1, ak);
         step(PN);
         chk("alarm_back_bit", 0, ab);
         chk("alarm_back_coil", 1, ac);
      end
      @(posedge mclk);
      rop <= 1'b0;
      step(1);
      chk("fault_alarm_bit", 1, ab);
      chk("fault_alarm_coil", 0, ac);
      @(posedge mclk);
      rop <= 1'b1;
      step(1);
      chk("healthy_alarm_coil", 1, ac);
      $display("test alarm pulses done");
      @(posedge mclk);
      xe <= 12'hFFF;
      step(1);
      chk("exp_bits", 12'hFFF, xb);
      chk("exp_contact", 12'h0F0, xk);
      @(posedge mclk);
      tw <= 1'b0;
      step(1);
      chk("exp_eight", 12'h0FF, xc);
      @(posedge mclk);
      fit <= 1'b0;
      step(1);
      chk("exp_absent", 12'h000, xb);
      @(posedge mclk);
      xe  <= 12'h000;
      tw  <= 1'b1;
      fit <= 1'b1;
      pulse(TGT_EXP_BASE + 5'h03, 1'b0);
      step(2);
      chk("exp_pulse", 12'h008, xb);
      step(PN);
      $display("test expansion done");
      do_reset(1'b1);
      @(posedge mclk);
      eq <= 7'h40;
      step(1);
      chk("seventh_bit", 0, mb[6]);
      chk("seventh_coil", 1, mc[6]);
      chk("alarm_open_contact", 1, ak);
      pulse(TGT_ALARM, 1'b0);
      step(2);
      chk("seventh_alarm", 0, mc[6]);
      chk("alarm_open_drop", 0, ak);
      $display("test extra alarm done");
      give_verdict();
   end
endmodule : tb_output_contact_driver
